// [verilog/xcvr_chan_pkg.sv]
// shared constants and carrier types for the channel fabric interface
package xcvr_chan_pkg;
  localparam int SYM_W = 10;
  localparam int WIDE_W = 32;
  localparam int HALF_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int ADDR_W = 6;
  localparam int MODE_W = 3;
  localparam int CHAN_W = 2;
  localparam int NUM_CHAN = 4;
  // bit positions inside each 16-bit half of the wide receive word
  localparam int POS_DATA = 0;
  localparam int POS_SYNC = 10;
  localparam int POS_DISPERR = 11;
  localparam int POS_PATDET = 12;
  localparam int POS_RMDEL = 13;
  localparam int POS_RMINS = 14;
  localparam int POS_RDISP = 15;
  localparam logic [MODE_W-1:0] MODE_CHAN_IF = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 6'h3f;

  typedef struct packed {
    logic [SYM_W-1:0] data;
    logic sync;
    logic dispErr;
    logic patDet;
    logic rmDel;
    logic rmIns;
    logic runDisp;
  } sym_type;

  typedef struct packed {
    sym_type hi;
    sym_type lo;
  } sym_pair_type;

  typedef enum logic [1:0] {
    RX_CLK_SHARED_TX,
    RX_CLK_OWN_TX,
    RX_CLK_OWN_RX
  } rx_clk_sel_type;

  typedef enum logic {
    TX_CLK_SHARED,
    TX_CLK_OWN
  } tx_clk_sel_type;
endpackage

// [verilog/sync_fifo.sv]
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic [AW:0] countNxt;
  logic doWr;
  logic doRd;

  // ready is registered from the next count, so it never lags a fill
  assign countNxt = count_r + (AW+1)'(doWr) - (AW+1)'(doRd);
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;

  always_ff @(posedge sys_clk) begin
    if (doWr) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
      inReady <= 1'b1;
    end else begin
      if (doWr) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (doRd) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      count_r <= countNxt;
      inReady <= (countNxt != (AW+1)'(DEPTH));
    end
  end
endmodule

// [verilog/xcvr_chan_fabric_if.sv]
// receive word packing, rx half-rate divider, core clock selection and reconfig status
// Notes on behaviour
// RULE_01 - 20-bit mode: lower symbol in bits 9:0, upper in 25:16
// RULE_02 - sync status of lower/upper symbol on bits 10 and 26
// RULE_03 - disparity error of lower/upper symbol on bits 11 and 27
// RULE_04 - pattern detect of lower/upper symbol on bits 12 and 28
// RULE_05 - rate-match deletion on bits 13 and 29, except PIPE mode
// RULE_06 - rate-match insertion on bits 14 and 30, except PIPE mode
// RULE_07 - running disparity of lower/upper symbol on bits 15 and 31
// RULE_08 - receiver has local divide-by-two giving half data rate
// RULE_09 - divider applies to receive path only; transmit rate unchanged
// RULE_10 - controller inputs: channel address, address reset, reset, mode, write-all
// RULE_11 - outputs address valid, 6-bit address, reconfig done and busy
// RULE_12 - tx fifo written by looped tx clock or fabric clock, fabric wins
// RULE_13 - shared tx clocking: channel 0 tx clock writes all tx fifos
// RULE_14 - per-channel tx clocking: own tx clock writes own tx fifo
// RULE_15 - rx fifo read by looped rx clock or fabric clock, fabric wins
// RULE_16 - shared rx option: channel 0 tx clock reads all rx fifos
// RULE_17 - own-tx rx option: own tx clock reads own rx fifo
// RULE_18 - own-rx rx option: own rx clock reads own rx fifo
// RULE_19 - fabric samples packed word in the rx fifo read domain
`timescale 1ns/1ps
module xcvr_chan_fabric_if
  import xcvr_chan_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // received symbol pair from the pcs
  input wire logic symValid,
  output logic symReady,
  input wire sym_pair_type symPair,
  input wire logic pipeMode,
  // wide receive word to fabric
  output logic [WIDE_W-1:0] rxWide,
  output logic rxWideValid,
  input wire logic rxWideReady,
  // rate control
  input wire logic rxHalfRate,
  input wire logic rxSerEn,
  output logic rxSymEn,
  output logic txSymEn,
  // core clock selection, per channel enables
  input wire tx_clk_sel_type txClkSel,
  input wire rx_clk_sel_type rxClkSel,
  input wire logic txCoreClkUse,
  input wire logic rxCoreClkUse,
  input wire logic [NUM_CHAN-1:0] txClkOut,
  input wire logic [NUM_CHAN-1:0] rxClkOut,
  input wire logic [NUM_CHAN-1:0] txCoreClk,
  input wire logic [NUM_CHAN-1:0] rxCoreClk,
  output logic [NUM_CHAN-1:0] txFifoWrClk,
  output logic [NUM_CHAN-1:0] rxFifoRdClk,
  // reconfiguration controller
  input wire logic [CHAN_W-1:0] logicalChanAddr,
  input wire logic resetReconfigAddr,
  input wire logic reconfigReset,
  input wire logic [MODE_W-1:0] reconfigModeSel,
  input wire logic writeAll,
  output logic reconfigAddrEn,
  output logic [ADDR_W-1:0] reconfigAddrOut,
  output logic channelReconfigDone,
  output logic busy,
  output logic [CHAN_W-1:0] activeChan
);
  logic fifoInReady;
  logic fifoOutValid;
  logic [WIDE_W-1:0] fifoOutData;
  logic [WIDE_W-1:0] packed_w;
  logic divPhase_r;
  logic busy_r;
  logic [ADDR_W-1:0] addr_r;

  // maps one symbol with status bits onto a 16-bit half
  function automatic logic [HALF_W-1:0] packHalf(input sym_type s, input logic pipe);
    logic [HALF_W-1:0] h;
    h = '0;
    h[POS_DATA +: SYM_W] = s.data;
    // RULE_02 sync status bit
    h[POS_SYNC] = s.sync;
    // RULE_03 disparity error bit
    h[POS_DISPERR] = s.dispErr;
    // RULE_04 pattern detect bit
    h[POS_PATDET] = s.patDet;
    // pipe mode forces the rate-match deletion and insertion bits to zero
    h[POS_RMDEL] = pipe ? 1'b0 : s.rmDel;
    h[POS_RMINS] = pipe ? 1'b0 : s.rmIns;
    // RULE_07 running disparity bit
    h[POS_RDISP] = s.runDisp;
    return h;
  endfunction

  // RULE_01 placement of both symbols
  // RULE_05 deletion flags gated by mode
  // RULE_06 insertion flags gated by mode
  assign packed_w = {packHalf(symPair.hi, pipeMode), packHalf(symPair.lo, pipeMode)};
  assign symReady = fifoInReady;

  // buffering absorbs fabric stalls; full back-pressures the pcs
  sync_fifo #(.WIDTH(WIDE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .inValid(symValid),
    .inReady(fifoInReady),
    .inData(packed_w),
    .outValid(fifoOutValid),
    .outReady(!rxWideValid || rxWideReady),
    .outData(fifoOutData)
  );

  // RULE_19 output register in read domain
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxWide <= '0;
      rxWideValid <= 1'b0;
    end else if (!rxWideValid || rxWideReady) begin
      rxWideValid <= fifoOutValid;
      if (fifoOutValid) begin
        rxWide <= fifoOutData;
      end
    end
  end

  // RULE_08 receive divide-by-two stage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      divPhase_r <= 1'b0;
      rxSymEn <= 1'b0;
    end else if (rxSerEn) begin
      divPhase_r <= rxHalfRate ? !divPhase_r : 1'b0;
      rxSymEn <= !rxHalfRate || divPhase_r;
    end else begin
      rxSymEn <= 1'b0;
    end
  end

  // RULE_09 transmit rate ignores the divider
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txSymEn <= 1'b0;
    end else begin
      txSymEn <= rxSerEn;
    end
  end

  // clock selections are registered as per-channel enables
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txFifoWrClk <= '0;
      rxFifoRdClk <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        // RULE_12 fabric tx clock overrides
        if (txCoreClkUse) begin
          txFifoWrClk[i] <= txCoreClk[i];
        // RULE_13 channel 0 shared
        end else if (txClkSel == TX_CLK_SHARED) begin
          txFifoWrClk[i] <= txClkOut[0];
        // RULE_14 own tx clock
        end else begin
          txFifoWrClk[i] <= txClkOut[i];
        end
        // RULE_15 fabric rx clock overrides
        if (rxCoreClkUse) begin
          rxFifoRdClk[i] <= rxCoreClk[i];
        end else begin
          unique case (rxClkSel)
            // RULE_16 channel 0 tx clock shared
            RX_CLK_SHARED_TX: rxFifoRdClk[i] <= txClkOut[0];
            // RULE_17 own tx clock
            RX_CLK_OWN_TX: rxFifoRdClk[i] <= txClkOut[i];
            // RULE_18 own rx clock
            RX_CLK_OWN_RX: rxFifoRdClk[i] <= rxClkOut[i];
            default: rxFifoRdClk[i] <= rxClkOut[i];
          endcase
        end
      end
    end
  end

  // RULE_10 control inputs start a channel write
  // RULE_11 address walk with busy and done
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      addr_r <= ADDR_RESET;
      busy <= 1'b0;
      reconfigAddrEn <= 1'b0;
      reconfigAddrOut <= ADDR_RESET;
      channelReconfigDone <= 1'b0;
      activeChan <= '0;
    end else if (reconfigReset) begin
      busy_r <= 1'b0;
      addr_r <= ADDR_RESET;
      busy <= 1'b0;
      reconfigAddrEn <= 1'b0;
      reconfigAddrOut <= ADDR_RESET;
      channelReconfigDone <= 1'b0;
    end else begin
      channelReconfigDone <= 1'b0;
      reconfigAddrEn <= 1'b0;
      if (resetReconfigAddr && !busy_r) begin
        addr_r <= ADDR_RESET;
        reconfigAddrOut <= ADDR_RESET;
      end else if (!busy_r && writeAll && reconfigModeSel == MODE_CHAN_IF) begin
        busy_r <= 1'b1;
        busy <= 1'b1;
        activeChan <= logicalChanAddr;
      end else if (busy_r) begin
        reconfigAddrEn <= 1'b1;
        reconfigAddrOut <= addr_r;
        if (addr_r == ADDR_LAST) begin
          busy_r <= 1'b0;
          busy <= 1'b0;
          channelReconfigDone <= 1'b1;
          addr_r <= ADDR_RESET;
        end else begin
          addr_r <= addr_r + 1'b1;
        end
      end
    end
  end

  chk_tx_shared: assert property (@(posedge sys_clk) disable iff (rst) // RULE_13
    (!txCoreClkUse && txClkSel == TX_CLK_SHARED)
    |=> txFifoWrClk == {NUM_CHAN{$past(txClkOut[0])}})
    else $error("tx shared clock");
  chk_tx_own: assert property (@(posedge sys_clk) disable iff (rst) // RULE_14
    (!txCoreClkUse && txClkSel == TX_CLK_OWN) |=> txFifoWrClk == $past(txClkOut))
    else $error("tx own clock");
  chk_rx_own_tx: assert property (@(posedge sys_clk) disable iff (rst) // RULE_17
    (!rxCoreClkUse && rxClkSel == RX_CLK_OWN_TX) |=> rxFifoRdClk == $past(txClkOut))
    else $error("rx own tx clock");
  chk_rx_own_rx: assert property (@(posedge sys_clk) disable iff (rst) // RULE_18
    (!rxCoreClkUse && rxClkSel == RX_CLK_OWN_RX) |=> rxFifoRdClk == $past(rxClkOut))
    else $error("rx own rx clock");
  // RULE_01 packed data matches inputs
  chk_data_pack: assert property (@(posedge sys_clk) disable iff (rst) // RULE_01
    packed_w[25:16] == symPair.hi.data && packed_w[9:0] == symPair.lo.data)
    else $error("data placement wrong");
  chk_status_pack: assert property (@(posedge sys_clk) disable iff (rst) // RULE_02
    packed_w[10] == symPair.lo.sync && packed_w[26] == symPair.hi.sync
    && packed_w[11] == symPair.lo.dispErr && packed_w[27] == symPair.hi.dispErr // RULE_03
    && packed_w[12] == symPair.lo.patDet && packed_w[28] == symPair.hi.patDet // RULE_04
    && packed_w[15] == symPair.lo.runDisp && packed_w[31] == symPair.hi.runDisp) // RULE_07
    else $error("status placement wrong");
  chk_rm_pipe: assert property (@(posedge sys_clk) disable iff (rst) // RULE_05
    pipeMode |-> (packed_w[14:13] == 2'b00 && packed_w[30:29] == 2'b00)) // RULE_06
    else $error("rate match flags in pipe mode");
  chk_half_rate: assert property (@(posedge sys_clk) disable iff (rst) // RULE_08
    (rxHalfRate && rxSerEn && rxSymEn) |=> !rxSymEn)
    else $error("half rate enable twice in a row");
  chk_tx_rate: assert property (@(posedge sys_clk) disable iff (rst) // RULE_09
    txSymEn == $past(rxSerEn)) else $error("tx rate affected");
  chk_done_idle: assert property (@(posedge sys_clk) disable iff (rst) // RULE_11
    channelReconfigDone |-> !busy && $past(busy)) else $error("done without busy");
  chk_tx_core: assert property (@(posedge sys_clk) disable iff (rst) // RULE_12
    txCoreClkUse |=> txFifoWrClk == $past(txCoreClk)) else $error("tx core clock");
  chk_rx_core: assert property (@(posedge sys_clk) disable iff (rst) // RULE_15
    rxCoreClkUse |=> rxFifoRdClk == $past(rxCoreClk)) else $error("rx core clock");
  chk_rx_shared: assert property (@(posedge sys_clk) disable iff (rst) // RULE_16
    (!rxCoreClkUse && rxClkSel == RX_CLK_SHARED_TX)
    |=> rxFifoRdClk == {NUM_CHAN{$past(txClkOut[0])}})
    else $error("rx shared clock");

  cov_half: cover property (@(posedge sys_clk) rxHalfRate && rxSymEn);
  cov_done: cover property (@(posedge sys_clk) channelReconfigDone);
  cov_full: cover property (@(posedge sys_clk) !fifoInReady);
  cov_pipe: cover property (@(posedge sys_clk) pipeMode && symValid && symReady);
  cov_abort: cover property (@(posedge sys_clk) busy && reconfigReset);
endmodule

// [testbench/fabric_sink.sv]
// fabric user logic model taking the wide receive word
`timescale 1ns/1ps
module fabric_sink
  import xcvr_chan_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // wide word from the channel
  input wire logic [WIDE_W-1:0] rxWide,
  input wire logic rxWideValid,
  output logic rxWideReady,
  // stall control
  input wire logic stall,
  input wire logic slow
);
  logic [WIDE_W-1:0] got[$];
  logic tick;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= ~tick;
      if (rxWideValid && rxWideReady) begin
        got.push_back(rxWide);
      end
    end
  end
  // slow mode takes a word every second cycle only
  assign rxWideReady = !stall && (!slow || tick);
endmodule

// [testbench/xcvr_chan_fabric_if_test.sv]
// scenario bench for the channel fabric interface
`timescale 1ns/1ps
module xcvr_chan_fabric_if_test
  import xcvr_chan_pkg::*;
();
  logic sys_clk = 1'b0, rst = 1'b1, symValid = 1'b0, symReady, pipeMode = 1'b0;
  logic rxWideValid, rxWideReady, rxHalfRate = 1'b0, rxSerEn = 1'b0, rxSymEn, txSymEn;
  sym_pair_type symPair = '0;
  logic [WIDE_W-1:0] rxWide;
  tx_clk_sel_type txClkSel = TX_CLK_SHARED;
  rx_clk_sel_type rxClkSel = RX_CLK_SHARED_TX;
  logic txCoreClkUse = 1'b0, rxCoreClkUse = 1'b0, stall = 1'b0, slow = 1'b0;
  logic [NUM_CHAN-1:0] txClkOut = 4'h1, rxClkOut = 4'h6, txCoreClk = 4'ha, rxCoreClk = 4'h9;
  logic [NUM_CHAN-1:0] txFifoWrClk, rxFifoRdClk;
  logic [CHAN_W-1:0] logicalChanAddr = 2'h2, activeChan;
  logic resetReconfigAddr = 1'b0, reconfigReset = 1'b0, writeAll = 1'b0;
  logic reconfigAddrEn, channelReconfigDone, busy;
  logic [MODE_W-1:0] reconfigModeSel = 3'h0;
  logic [ADDR_W-1:0] reconfigAddrOut;
  int n_fail = 0, total_checks = 0;

  xcvr_chan_fabric_if u_xcvr_chan_fabric_if (.sys_clk, .rst, .symValid, .symReady,
    .symPair, .pipeMode, .rxWide, .rxWideValid, .rxWideReady, .rxHalfRate, .rxSerEn,
    .rxSymEn, .txSymEn, .txClkSel, .rxClkSel, .txCoreClkUse, .rxCoreClkUse, .txClkOut,
    .rxClkOut, .txCoreClk, .rxCoreClk, .txFifoWrClk, .rxFifoRdClk, .logicalChanAddr,
    .resetReconfigAddr, .reconfigReset, .reconfigModeSel, .writeAll, .reconfigAddrEn,
    .reconfigAddrOut, .channelReconfigDone, .busy, .activeChan);
  fabric_sink u_fabric_sink (.sys_clk, .rst, .rxWide, .rxWideValid, .rxWideReady,
    .stall, .slow);

  always #4 sys_clk = ~sys_clk;

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic hang(string what);
    chk(what, 32'h1, 32'h0);
    results();
  endtask

  function automatic logic [15:0] pk(sym_type s, logic p);
    return {s.runDisp, s.rmIns & ~p, s.rmDel & ~p, s.patDet, s.dispErr, s.sync, s.data};
  endfunction

  function automatic sym_pair_type mk(int n);
    return sym_pair_type'({16'h5a5a ^ 16'(n), 16'hc3c3 + 16'(n)});
  endfunction

  task automatic wait_words(int n);
    int i;
    for (i = 0; i < 300 && u_fabric_sink.got.size() < n; i++) begin
      @(negedge sys_clk);
    end
    if (u_fabric_sink.got.size() < n) hang("word wait");
  endtask

  // all status bits set; rate-match bits must vanish in pipe mode
  task automatic pipe_word();
    pipeMode = 1'b1;
    symPair = '1;
    symValid = 1'b1;
    @(negedge sys_clk);
    symValid = 1'b0;
    wait_words(1);
    chk("pipe word", u_fabric_sink.got[0], {pk('1, 1'b1), pk('1, 1'b1)});
    u_fabric_sink.got.delete();
    pipeMode = 1'b0;
  endtask

  // sink stalled: count accepts until full, then drain slowly and compare order
  task automatic fifo_fill();
    int n;
    int i;
    logic take;
    sym_pair_type p;
    n = 0;
    stall = 1'b1;
    symValid = 1'b1;
    for (i = 0; i < 30; i++) begin
      symPair = mk(n);
      take = symReady;
      @(negedge sys_clk);
      if (take === 1'b1) n++;
    end
    symValid = 1'b0;
    chk("accepted", n, 17);
    slow = 1'b1;
    stall = 1'b0;
    wait_words(n);
    for (i = 0; i < n; i++) begin
      p = mk(i);
      chk("wide word", u_fabric_sink.got[i], {pk(p.hi, 1'b0), pk(p.lo, 1'b0)});
    end
    u_fabric_sink.got.delete();
    slow = 1'b0;
  endtask

  task automatic divider(logic half, int exp);
    int r;
    int t;
    int i;
    r = 0;
    t = 0;
    rxHalfRate = half;
    rxSerEn = 1'b1;
    repeat (3) @(negedge sys_clk);
    for (i = 0; i < 20; i++) begin
      @(negedge sys_clk);
      if (rxSymEn === 1'b1) r++;
      if (txSymEn === 1'b1) t++;
    end
    chk("rx rate", r, exp);
    chk("tx rate", t, 20);
    rxSerEn = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic sel(tx_clk_sel_type t, rx_clk_sel_type r, logic c, logic [3:0] et, er);
    txClkSel = t;
    rxClkSel = r;
    txCoreClkUse = c;
    rxCoreClkUse = c;
    repeat (2) @(negedge sys_clk);
    chk("tx wr clk", txFifoWrClk, et);
    chk("rx rd clk", rxFifoRdClk, er);
  endtask

  task automatic reconfig();
    int i;
    int k;
    logic done;
    k = 0;
    done = 1'b0;
    reconfigModeSel = 3'h2;
    writeAll = 1'b1;
    @(negedge sys_clk);
    writeAll = 1'b0;
    @(negedge sys_clk);
    chk("busy wrong mode", busy, 1'b0);
    reconfigModeSel = MODE_CHAN_IF;
    writeAll = 1'b1;
    @(negedge sys_clk);
    writeAll = 1'b0;
    for (i = 0; i < 200 && !done; i++) begin
      @(negedge sys_clk);
      if (reconfigAddrEn === 1'b1) begin
        chk("walk addr", 32'(reconfigAddrOut), k);
        k++;
      end
      if (channelReconfigDone === 1'b1) begin
        done = 1'b1;
        chk("last addr", reconfigAddrOut, ADDR_LAST);
      end
    end
    if (!done) hang("reconfig done");
    chk("addr count", k, 64);
    chk("busy end", busy, 1'b0);
    chk("active chan", activeChan, 2'h2);
    // idle address reset pulls the last address back to the start
    resetReconfigAddr = 1'b1;
    @(negedge sys_clk);
    resetReconfigAddr = 1'b0;
    @(negedge sys_clk);
    chk("addr reset", reconfigAddrOut, ADDR_RESET);
    // a second walk on another channel, aborted midway by the controller reset
    logicalChanAddr = 2'h1;
    writeAll = 1'b1;
    @(negedge sys_clk);
    writeAll = 1'b0;
    repeat (5) @(negedge sys_clk);
    chk("busy mid", busy, 1'b1);
    chk("active chan", activeChan, 2'h1);
    chk("addr mid", reconfigAddrOut, 6'h04);
    reconfigReset = 1'b1;
    @(negedge sys_clk);
    reconfigReset = 1'b0;
    @(negedge sys_clk);
    chk("busy abort", busy, 1'b0);
    chk("addr abort", reconfigAddrOut, ADDR_RESET);
  endtask

  initial begin
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    pipe_word();
    fifo_fill();
    divider(1'b0, 20);
    divider(1'b1, 10);
    sel(TX_CLK_SHARED, RX_CLK_SHARED_TX, 1'b0, 4'hf, 4'hf);
    sel(TX_CLK_OWN, RX_CLK_OWN_TX, 1'b0, 4'h1, 4'h1);
    sel(TX_CLK_OWN, RX_CLK_OWN_RX, 1'b0, 4'h1, 4'h6);
    sel(TX_CLK_SHARED, RX_CLK_SHARED_TX, 1'b1, 4'ha, 4'h9);
    reconfig();
    results();
  end
endmodule
